// ---- core/temp_sensor_slave.sv ----
// SMBus slave and over-temperature comparator of the remote diode sensor.
// Assumes temperature results arrive on the system clock with a load
// pulse; bus pins and straps are asynchronous and are synchronised here.
`timescale 1ns/1ns

// Overview of operation
// - Alarm when any temperature exceeds its limit
// - Host writes and reads back critical limits
// - Nine slave addresses from two tri-level straps
// - Limit resets to 127 degrees
// - Temperatures are eight-bit signed bytes
// - Temperatures readable anytime without trigger
// - SMBus slave with clock-low timeout release
// - Alarm pin is open-drain, pulled low
// - Data line open-drain, clock input only
// - Separate local and remote limits, both 127
module temp_sensor_slave #(
	parameter int TIMEOUT_CYCLES = temp_sensor_pkg::TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic serial_clock_pin,
	input wire logic serial_data_line_in,
	output logic serial_data_line_out,
	output logic serial_data_line_oe_n,
	input wire logic [1:0] addr_select_lo_pin,
	input wire logic [1:0] addr_select_hi_pin,
	input wire logic [7:0] local_temp,
	input wire logic [7:0] remote_temp,
	input wire logic temp_load,
	output logic critical_alarm_out,
	output logic critical_alarm_oe_n
);
	typedef struct packed {
		logic scl_m, scl_s, scl_p;
		logic sda_m, sda_s, sda_p;
		logic [1:0] alo_m, alo_s, ahi_m, ahi_s;
		temp_sensor_pkg::bus_state_e st;
		logic [2:0] cnt;
		logic full;
		logic [7:0] sh;
		logic rw;
		logic got_cmd;
		logic [7:0] cmd;
		logic ack_ok;
		logic [19:0] timer;
		logic [7:0] loc_temp, rem_temp;
		logic [7:0] crit_local, crit_remote;
		logic sda_oe_n, sda_o;
		logic alarm_oe_n, alarm_o;
	} state_s;

	state_s st_q, st_d;
	logic rise, fall, start, stop;
	logic [6:0] my_addr;
	logic [7:0] rd_byte;
	logic over_l, over_r;

	// Signed compare of a reading against its limit
	function automatic logic over_limit(input logic [7:0] t,
		input logic [7:0] lim);
		over_limit = $signed(t) > $signed(lim);
	endfunction

	// Map one tri-level strap to 0, 1 or 2
	function automatic logic [3:0] strap_val(input logic [1:0] s);
		unique case (s)
			temp_sensor_pkg::STRAP_LOW: strap_val = 4'h0;
			temp_sensor_pkg::STRAP_HIGH: strap_val = 4'h1;
			default: strap_val = 4'h2;
		endcase
	endfunction

	// Bus events from the synchronised pins
	assign rise = st_q.scl_s & ~st_q.scl_p;
	assign fall = ~st_q.scl_s & st_q.scl_p;
	assign start = st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s;
	assign stop = st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s;
	// Slave address from the two straps
	assign my_addr = temp_sensor_pkg::ADDR_BASE + 7'(strap_val(st_q.ahi_s)
		* 4'h3 + strap_val(st_q.alo_s));
	assign over_l = over_limit(st_q.loc_temp, st_q.crit_local);
	assign over_r = over_limit(st_q.rem_temp, st_q.crit_remote);

	// Byte returned for the selected register
	always_comb begin
		unique case (st_q.cmd)
			temp_sensor_pkg::CMD_LOCAL_TEMP: rd_byte = st_q.loc_temp;
			temp_sensor_pkg::CMD_REMOTE_TEMP: rd_byte = st_q.rem_temp;
			temp_sensor_pkg::CMD_LOCAL_LIMIT: rd_byte = st_q.crit_local;
			temp_sensor_pkg::CMD_REMOTE_LIMIT: rd_byte = st_q.crit_remote;
			default: rd_byte = temp_sensor_pkg::UNMAPPED_READ;
		endcase
	end

	// Next state of synchronisers, serial engine, limits and alarm
	always_comb begin
		st_d = st_q;
		st_d.scl_m = serial_clock_pin;
		st_d.scl_s = st_q.scl_m;
		st_d.scl_p = st_q.scl_s;
		st_d.sda_m = serial_data_line_in;
		st_d.sda_s = st_q.sda_m;
		st_d.sda_p = st_q.sda_s;
		st_d.alo_m = addr_select_lo_pin;
		st_d.alo_s = st_q.alo_m;
		st_d.ahi_m = addr_select_hi_pin;
		st_d.ahi_s = st_q.ahi_m;
		st_d.sda_o = 1'b0;
		st_d.alarm_o = 1'b0;
		// Results are taken whole, eight-bit two's complement
		if (temp_load) begin
			st_d.loc_temp = local_temp;
			st_d.rem_temp = remote_temp;
		end
		// Level alarm, no latching; pin only ever pulled low
		st_d.alarm_oe_n = ~(over_l | over_r);
		// Clock-low watchdog while a transfer is open
		if (st_q.st == temp_sensor_pkg::S_IDLE || st_q.scl_s)
			st_d.timer = 20'h00000;
		else
			st_d.timer = st_q.timer + 20'h00001;
		if (start) begin
			st_d.st = temp_sensor_pkg::S_ADDR;
			st_d.cnt = 3'h0;
			st_d.full = 1'b0;
			st_d.got_cmd = 1'b0;
			st_d.sda_oe_n = 1'b1;
		end else if (stop) begin
			st_d.st = temp_sensor_pkg::S_IDLE;
			st_d.sda_oe_n = 1'b1;
		end else if (st_q.st != temp_sensor_pkg::S_IDLE &&
			st_q.timer >= 20'(TIMEOUT_CYCLES - 1)) begin
			st_d.st = temp_sensor_pkg::S_IDLE;
			st_d.sda_oe_n = 1'b1;
		end else if (rise) begin
			unique case (st_q.st)
				temp_sensor_pkg::S_ADDR, temp_sensor_pkg::S_RX: begin
					st_d.sh = {st_q.sh[6:0], st_q.sda_s};
					st_d.cnt = st_q.cnt + 3'h1;
					st_d.full = (st_q.cnt == 3'h7);
				end
				temp_sensor_pkg::S_TX: begin
					st_d.cnt = st_q.cnt + 3'h1;
					st_d.full = (st_q.cnt == 3'h7);
				end
				temp_sensor_pkg::S_MACK: st_d.ack_ok = ~st_q.sda_s;
				default: ;
			endcase
		end else if (fall) begin
			unique case (st_q.st)
				temp_sensor_pkg::S_ADDR: if (st_q.full) begin
					st_d.full = 1'b0;
					if (st_q.sh[7:1] == my_addr) begin
						st_d.st = temp_sensor_pkg::S_ACK;
						st_d.rw = st_q.sh[0];
						st_d.sda_oe_n = 1'b0;
					end else begin
						st_d.st = temp_sensor_pkg::S_IDLE;
					end
				end
				temp_sensor_pkg::S_RX: if (st_q.full) begin
					st_d.full = 1'b0;
					st_d.st = temp_sensor_pkg::S_ACK;
					st_d.sda_oe_n = 1'b0;
					if (!st_q.got_cmd) begin
						st_d.cmd = st_q.sh;
						st_d.got_cmd = 1'b1;
					end else if (st_q.cmd == temp_sensor_pkg::CMD_LOCAL_LIMIT) begin
						st_d.crit_local = st_q.sh;
					end else if (st_q.cmd == temp_sensor_pkg::CMD_REMOTE_LIMIT) begin
						st_d.crit_remote = st_q.sh;
					end
				end
				temp_sensor_pkg::S_ACK: begin
					st_d.cnt = 3'h0;
					if (st_q.rw) begin
						st_d.st = temp_sensor_pkg::S_TX;
						st_d.sh = rd_byte;
						st_d.sda_oe_n = rd_byte[7];
					end else begin
						st_d.st = temp_sensor_pkg::S_RX;
						st_d.sda_oe_n = 1'b1;
					end
				end
				temp_sensor_pkg::S_TX: begin
					if (st_q.full) begin
						st_d.full = 1'b0;
						st_d.st = temp_sensor_pkg::S_MACK;
						st_d.sda_oe_n = 1'b1;
					end else begin
						st_d.sh = {st_q.sh[6:0], 1'b0};
						st_d.sda_oe_n = st_q.sh[6];
					end
				end
				temp_sensor_pkg::S_MACK: begin
					st_d.cnt = 3'h0;
					if (st_q.ack_ok) begin
						st_d.st = temp_sensor_pkg::S_TX;
						st_d.sh = rd_byte;
						st_d.sda_oe_n = rd_byte[7];
					end else begin
						st_d.st = temp_sensor_pkg::S_IDLE;
					end
				end
				default: ;
			endcase
		end
	end

	// State register; limits come up at +127
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= '0;
			st_q.scl_m <= 1'b1;
			st_q.scl_s <= 1'b1;
			st_q.scl_p <= 1'b1;
			st_q.sda_m <= 1'b1;
			st_q.sda_s <= 1'b1;
			st_q.sda_p <= 1'b1;
			st_q.st <= temp_sensor_pkg::S_IDLE;
			st_q.crit_local <= temp_sensor_pkg::LIMIT_RESET;
			st_q.crit_remote <= temp_sensor_pkg::LIMIT_RESET;
			st_q.sda_oe_n <= 1'b1;
			st_q.alarm_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Pin drivers straight from flops
	assign serial_data_line_out = st_q.sda_o;
	assign serial_data_line_oe_n = st_q.sda_oe_n;
	assign critical_alarm_out = st_q.alarm_o;
	assign critical_alarm_oe_n = st_q.alarm_oe_n;

	a_alarm_raise: assert property (@(posedge clk_sys) disable iff (reset)
		(over_l || over_r) |=> !critical_alarm_oe_n)
		else $error("alarm not raised above limit");
	a_alarm_clear: assert property (@(posedge clk_sys) disable iff (reset)
		(!over_l && !over_r) |=> critical_alarm_oe_n)
		else $error("alarm held at or below limit");
	a_limit_default: assert property (@(posedge clk_sys) disable iff (reset)
		$past(reset) |->
		(st_q.crit_local == temp_sensor_pkg::LIMIT_RESET &&
		st_q.crit_remote == temp_sensor_pkg::LIMIT_RESET))
		else $error("limits not at default after reset");
	a_idle_release: assert property (@(posedge clk_sys) disable iff (reset)
		st_q.st == temp_sensor_pkg::S_IDLE |-> serial_data_line_oe_n &&
		!serial_data_line_out)
		else $error("data line driven while idle");
	a_timeout_release: assert property (@(posedge clk_sys)
		disable iff (reset)
		(st_q.st != temp_sensor_pkg::S_IDLE && !start && !stop &&
		st_q.timer >= 20'(TIMEOUT_CYCLES - 1)) |=>
		st_q.st == temp_sensor_pkg::S_IDLE && serial_data_line_oe_n)
		else $error("bus not released on timeout");
	a_addr_miss: assert property (@(posedge clk_sys) disable iff (reset)
		(fall && !start && !stop && st_q.timer < 20'(TIMEOUT_CYCLES - 1) &&
		st_q.st == temp_sensor_pkg::S_ADDR && st_q.full) |=>
		(st_q.st == temp_sensor_pkg::S_ACK) ==
		($past(st_q.sh[7:1]) == $past(my_addr)))
		else $error("address acknowledge mismatch");
	a_limit_write: assert property (@(posedge clk_sys) disable iff (reset)
		(fall && !start && !stop && st_q.timer < 20'(TIMEOUT_CYCLES - 1) &&
		st_q.st == temp_sensor_pkg::S_RX && st_q.full && st_q.got_cmd &&
		st_q.cmd == temp_sensor_pkg::CMD_REMOTE_LIMIT) |=>
		st_q.crit_remote == $past(st_q.sh))
		else $error("remote limit not written");
	a_cmd_capture: assert property (@(posedge clk_sys) disable iff (reset)
		(fall && !start && !stop && st_q.timer < 20'(TIMEOUT_CYCLES - 1) &&
		st_q.st == temp_sensor_pkg::S_RX && st_q.full && !st_q.got_cmd) |=>
		st_q.got_cmd && st_q.cmd == $past(st_q.sh) &&
		!serial_data_line_oe_n)
		else $error("command byte not captured");
	a_temp_load: assert property (@(posedge clk_sys) disable iff (reset)
		temp_load |=> st_q.rem_temp == $past(remote_temp) &&
		st_q.loc_temp == $past(local_temp))
		else $error("temperature byte altered");
	a_ack_drive: assert property (@(posedge clk_sys) disable iff (reset)
		st_q.st == temp_sensor_pkg::S_ACK |-> !serial_data_line_oe_n)
		else $error("acknowledge not driven");
endmodule

// ---- inc/temp_sensor_pkg.sv ----
// Constants shared by the temperature sensor serial slave.
// Assumes a 20 MHz system clock and an SMBus host that drives the clock.
package temp_sensor_pkg;
	// System clock rate and bus timeout
	localparam int CLK_HZ = 20_000_000;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
	// Critical limit reset value, +127 degrees
	localparam logic [7:0] LIMIT_RESET = 8'h7f;
	// Command codes that select the register behind the pointer
	localparam logic [7:0] CMD_LOCAL_TEMP = 8'h00;
	localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
	localparam logic [7:0] CMD_LOCAL_LIMIT = 8'h02;
	localparam logic [7:0] CMD_REMOTE_LIMIT = 8'h03;
	// Value returned for an unmapped command code
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Base slave address; the strap index 0..8 is added to it
	localparam logic [6:0] ADDR_BASE = 7'h18;
	// Tri-level strap codes as sensed by the pin front end
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_OPEN = 2'h2;
	// Serial engine states
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_MACK
	} bus_state_e;
endpackage

// ---- sim/smbus_host.sv ----
// Behavioural SMBus host that toggles the clock and data wire.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module smbus_host (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_wire
);
	// Clock stands high and data released outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Start or repeated start, clock left low
	task automatic start_cond();
		#100 sda_drv = 1'b1;
		#100 scl = 1'b1;
		#200 sda_drv = 1'b0;
		#200 scl = 1'b0;
	endtask
	// Stop condition closes the frame
	task automatic stop_cond();
		#100 sda_drv = 1'b0;
		#100 scl = 1'b1;
		#200 sda_drv = 1'b1;
		#200;
	endtask
	// Data moves in the low phase, wire sampled in the high phase
	task automatic bit_io(input logic b, output logic s);
		#100 sda_drv = b;
		#100 scl = 1'b1;
		#100 s = sda_wire;
		#100 scl = 1'b0;
	endtask
	// Byte MSB first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic mack_n,
		output logic [7:0] q, output logic ack_n);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(mack_n, ack_n);
	endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the sensor serial slave.
// Assumes a pulled-up data wire and alarm wire.
`timescale 1ns/1ns
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic temp_load = 1'b0;
	logic [1:0] lo_s = 2'h0;
	logic [1:0] hi_s = 2'h0;
	logic [7:0] loc_t = 8'h00;
	logic [7:0] rem_t = 8'h00;
	logic scl, host_sda, sd_out, sd_oe_n, al_out, al_oe_n, a;
	logic [7:0] q;
	logic [6:0] ad = 7'h18;
	int fail_count = 0;
	int num_checks = 0;
	wire sda_wire = host_sda & (sd_oe_n | sd_out);
	wire alarm_pin = al_oe_n | al_out;
	// Free-running system clock
	always #25 clk_sys = ~clk_sys;
	temp_sensor_slave #(.TIMEOUT_CYCLES(200)) u_temp_sensor_slave (
		.clk_sys(clk_sys), .reset(reset), .serial_clock_pin(scl),
		.serial_data_line_in(sda_wire), .serial_data_line_out(sd_out),
		.serial_data_line_oe_n(sd_oe_n), .addr_select_lo_pin(lo_s),
		.addr_select_hi_pin(hi_s), .local_temp(loc_t),
		.remote_temp(rem_t), .temp_load(temp_load),
		.critical_alarm_out(al_out), .critical_alarm_oe_n(al_oe_n));
	smbus_host u_smbus_host (.scl(scl), .sda_drv(host_sda),
		.sda_wire(sda_wire));
	// Compare and count
	task automatic check(input string nm, input logic [7:0] s, e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Byte from host with its acknowledge judged
	task automatic put(input logic [7:0] d);
		u_smbus_host.byte_io(d, 1'b1, q, a);
		check("ack", {7'h00, a}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] c, d);
		u_smbus_host.start_cond();
		put({ad, 1'b0});
		put(c);
		put(d);
		u_smbus_host.stop_cond();
	endtask
	task automatic rd(input logic [7:0] c, e, input string nm);
		u_smbus_host.start_cond();
		put({ad, 1'b0});
		put(c);
		u_smbus_host.start_cond();
		put({ad, 1'b1});
		u_smbus_host.byte_io(8'hff, 1'b1, q, a);
		u_smbus_host.stop_cond();
		check(nm, q, e);
	endtask
	task automatic t_reset_limits();
		rd(8'h02, 8'h7f, "local limit");
		rd(8'h03, 8'h7f, "remote limit");
	endtask
	task automatic t_temps();
		@(negedge clk_sys);
		loc_t = 8'hd8;
		rem_t = 8'h55;
		temp_load = 1'b1;
		@(negedge clk_sys);
		temp_load = 1'b0;
		rd(8'h00, 8'hd8, "local temp");
		rd(8'h01, 8'h55, "remote temp");
	endtask
	task automatic t_alarm();
		check("alarm idle", {7'h00, alarm_pin}, 8'h01);
		wr(8'h03, 8'h50);
		rd(8'h03, 8'h50, "limit back");
		check("alarm above", {7'h00, alarm_pin}, 8'h00);
		wr(8'h03, 8'h55);
		check("alarm equal", {7'h00, alarm_pin}, 8'h01);
		wr(8'h02, 8'hd0);
		check("alarm signed", {7'h00, alarm_pin}, 8'h00);
		wr(8'h02, 8'h7f);
		check("alarm clear", {7'h00, alarm_pin}, 8'h01);
	endtask
	task automatic t_address();
		for (int h = 0; h < 3; h++)
			for (int l = 0; l < 3; l++) begin
				@(negedge clk_sys);
				hi_s = h[1:0];
				lo_s = l[1:0];
				ad = 7'h18 + 7'(3 * h + l);
				repeat (4) @(negedge clk_sys);
				rd(8'h03, 8'h55, "strap read");
			end
		u_smbus_host.start_cond();
		u_smbus_host.byte_io({7'h18, 1'b0}, 1'b1, q, a);
		u_smbus_host.stop_cond();
		check("foreign nack", {7'h00, a}, 8'h01);
	endtask
	task automatic t_timeout();
		logic [7:0] aw;
		aw = {ad, 1'b0};
		u_smbus_host.start_cond();
		for (int i = 7; i >= 0; i--)
			u_smbus_host.bit_io(aw[i], a);
		repeat (10) @(negedge clk_sys);
		check("ack held", {7'h00, sd_oe_n}, 8'h00);
		repeat (250) @(negedge clk_sys);
		check("timeout free", {7'h00, sd_oe_n}, 8'h01);
		u_smbus_host.stop_cond();
		rd(8'h03, 8'h55, "after timeout");
	endtask
	// Ignored temp write, unmapped read, burst read, read on last command
	task automatic t_more();
		wr(8'h01, 8'h12);
		rd(8'h01, 8'h55, "temp write ignored");
		rd(8'h07, temp_sensor_pkg::UNMAPPED_READ, "unmapped");
		u_smbus_host.start_cond();
		put({ad, 1'b0});
		put(8'h02);
		u_smbus_host.start_cond();
		put({ad, 1'b1});
		u_smbus_host.byte_io(8'hff, 1'b0, q, a);
		check("burst first", q, 8'h7f);
		u_smbus_host.byte_io(8'hff, 1'b1, q, a);
		check("burst second", q, 8'h7f);
		u_smbus_host.start_cond();
		put({ad, 1'b1});
		u_smbus_host.byte_io(8'hff, 1'b1, q, a);
		u_smbus_host.stop_cond();
		check("last command", q, 8'h7f);
	endtask
	// Reset in mid-run brings limits back and drops the alarm
	task automatic t_reset_again();
		wr(8'h03, 8'h42);
		check("alarm before", {7'h00, alarm_pin}, 8'h00);
		@(negedge clk_sys);
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		check("alarm reset", {7'h00, alarm_pin}, 8'h01);
		rd(8'h03, temp_sensor_pkg::LIMIT_RESET, "limit reload");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_reset_limits();
		t_temps();
		t_alarm();
		t_address();
		t_timeout();
		t_more();
		t_reset_again();
		complete_run();
	end
	// Watchdog well past the expected run
	initial begin
		#3_000_000;
		fail_count++;
		complete_run();
	end
endmodule
